// ### eec_top.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - One counter for all sequences to recipient
// - Send only if credit>0 and count<credit
// - Login or credit reset clears counter
// - Connect request loads one, then increment
// - Class 2 data increments; ACK_0 freezes
// - History-1 ACK_1, busy, reject decrement one
// - History-0 ACK_1 also reclaims lower frames
// - ACK_N subtracts N, plus lower if history 0
// - Terminating ACK reclaims all lower frames
// - ACK_0 ends sequence, counter unchanged
// - Credit least and default is one
// - Counter never drops below zero
module eec_top
   import eec_pkg::*;
#(
   parameter int SEQS = 16
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 srst,
   // Register port
   input  wire logic [3:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic [31:0]               reg_rdata,
   // Transmit path
   input  wire logic                 tx_req,
   input  wire logic                 tx_sofc1,
   input  wire logic                 tx_class1,
   input  wire logic [EEC_SEQ_W-1:0] tx_seq,
   input  wire logic [EEC_SC_W-1:0]  tx_sc,
   output logic                      tx_allow,
   output logic                      tx_taken,
   // Responses received
   input  wire logic                 rsp_valid,
   input  wire eec_rsp_e             rsp_kind,
   input  wire logic [EEC_SEQ_W-1:0] rsp_seq,
   input  wire logic [EEC_SC_W-1:0]  rsp_sc,
   input  wire logic [EEC_CNT_W-1:0] rsp_ackcnt,
   input  wire logic                 rsp_hist,
   input  wire logic                 rsp_term,
   // Status
   output logic [EEC_CNT_W-1:0]      credit_cnt,
   output logic                      seq_done,
   output logic [EEC_SEQ_W-1:0]      seq_done_id
);
   localparam int SCW = 1 << EEC_SC_W;

   initial begin
      if (SEQS != (1 << EEC_SEQ_W))
         $error("eec_top SEQS must match slot index width");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [EEC_CNT_W-1:0] credit;     // Granted end-to-end credit
      logic                 ack0;       // ACK_0 mode, no counting
      logic [EEC_CNT_W-1:0] cnt;        // Outstanding frames, all sequences
      logic                 allow;      // Registered send permission
      logic                 taken;      // Frame accepted pulse
      logic                 done;       // ACK_0 seen pulse
      logic [EEC_SEQ_W-1:0] done_id;    // Sequence of that ACK_0
      logic [31:0]          rdata;      // Read data
      logic [7:0]           ignored;    // Late ACKs discarded
   } eec_top_s;

   eec_top_s st;          // Registered state
   eec_top_s next_st;     // Next state, from the next-state always_comb

   // ------------------------------------------------------------
   // Local nets
   // ------------------------------------------------------------
   // Window bitmap hookup
   logic [SCW-1:0] rc_pend;      // Pending frames of responding sequence
   logic [SCW-1:0] rc_mask;      // Bits to reclaim
   logic           rc_do;        // Reclaim strobe
   logic           tx_ok;        // Frame accepted this cycle
   logic [EEC_CNT_W-1:0] dec;    // Total decrement
   logic           win_clr;      // Empties the pending record

   // A login leaves no frame outstanding, so the pending bits must go as
   // well; stale ones would let a later History-0 ACK reclaim phantom credit.
   assign win_clr = srst || (reg_wr && (reg_addr == EEC_REG_RELOG));

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   // Count of set bits in a mask
   // At most 64 bits set, which still fits the counter width
   function automatic logic [EEC_CNT_W-1:0] popc(input logic [SCW-1:0] v);
      logic [EEC_CNT_W-1:0] n;
      n = '0;
      for (int i = 0; i < SCW; i++) begin
         n = n + {{(EEC_CNT_W-1){1'b0}}, v[i]};
      end
      return n;
   endfunction

   // Mask of SEQ_CNT values strictly below a position
   // One compare per window bit; cheap at 64 entries
   function automatic logic [SCW-1:0] below(input logic [EEC_SC_W-1:0] p);
      logic [SCW-1:0] m;
      m = '0;
      for (int i = 0; i < SCW; i++) begin
         m[i] = (i < int'(p));
      end
      return m;
   endfunction

   // ------------------------------------------------------------
   // Pending bitmap store
   // ------------------------------------------------------------
   eec_window #(
      .SEQS (SEQS),
      .SCW  (SCW)
   ) u_win (
      .clk     (clk),
      .srst    (win_clr),
      .tx_mark (tx_ok && !st.ack0),
      .tx_seq  (tx_seq),
      .tx_sc   (tx_sc),
      .rc_do   (rc_do),
      .rc_seq  (rsp_seq),
      .rc_mask (rc_mask),
      .rc_pend (rc_pend)
   );

   // ------------------------------------------------------------
   // Response decode: which pending frames this response frees
   // ------------------------------------------------------------
   // Only bits still pending are counted, so a late ACK whose frame was
   // already reclaimed frees nothing and costs no credit.
   always_comb begin
      logic [SCW-1:0] own;
      logic [SCW-1:0] lower;
      logic [SCW-1:0] nmask;
      own   = '0;
      lower = below(rsp_sc);
      nmask = '0;
      rc_mask = '0;
      rc_do   = 1'b0;
      dec     = '0;
      own[rsp_sc] = 1'b1;
      // Run of N frames ending at SEQ_CNT
      for (int i = 0; i < SCW; i++) begin
         nmask[i] = (i <= int'(rsp_sc)) && (int'(rsp_sc) - i < int'(rsp_ackcnt));
      end
      if (rsp_valid && !st.ack0) begin
         case (rsp_kind)
            EEC_RSP_ACK1: begin
               rc_mask = own;
               if (!rsp_hist || rsp_term) begin
                  rc_mask = own | lower;
               end
            end
            EEC_RSP_ACKN: begin
               rc_mask = nmask;
               if (!rsp_hist || rsp_term) begin
                  rc_mask = nmask | lower;
               end
            end
            // Busy and reject free only the frame they name
            EEC_RSP_BSY, EEC_RSP_RJT: begin
               rc_mask = own;
            end
            default: begin
               rc_mask = '0;
            end
         endcase
         rc_do = 1'b1;
         dec   = popc(rc_mask & rc_pend);
      end
   end

   // Frame accepted when requested and permitted; counted unless in ACK_0 mode
   // A refused request is dropped, never queued or counted
   assign tx_ok = tx_req && st.allow;

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      logic [EEC_CNT_W-1:0] c;
      logic                 late;
      c    = st.cnt;
      late = rsp_valid && !st.ack0 && (rsp_kind != EEC_RSP_ACK0)
             && ((rc_mask & rc_pend) == '0);
      next_st = st;
      next_st.taken = 1'b0;
      next_st.done  = 1'b0;
      next_st.rdata = '0;

      // Credit decrement, floored at zero
      if (dec > c) begin
         c = '0;
      end else begin
         c = c - dec;
      end
      if (late) begin
         next_st.ignored = st.ignored + 8'h01;
      end

      // Transmit accounting shares the one counter
      if (tx_ok) begin
         next_st.taken = 1'b1;
         if (!st.ack0) begin
            if (tx_class1 && tx_sofc1) begin
               c = EEC_CNT_SOFC1;
            end else begin
               c = c + EEC_ONE;
            end
         end
      end

      // ACK_0 marks sequence end only
      if (rsp_valid && rsp_kind == EEC_RSP_ACK0) begin
         next_st.done    = 1'b1;
         next_st.done_id = rsp_seq;
      end

      // Register writes
      // Unmapped addresses leave every field as it was
      if (reg_wr) begin
         case (reg_addr)
            EEC_REG_CTRL: begin
               next_st.credit = reg_wdata[EEC_CTRL_CR_LSB +: EEC_CNT_W];
               if (reg_wdata[EEC_CTRL_CR_LSB +: EEC_CNT_W] == '0) begin
                  next_st.credit = EEC_CREDIT_DEF;
               end
               next_st.ack0 = reg_wdata[EEC_CTRL_ACK0];
            end
            EEC_REG_RELOG: begin
               c = EEC_CNT_RST;
            end
            default: begin
               next_st.ack0 = st.ack0;
            end
         endcase
      end
      next_st.cnt = c;

      // Permission for the next cycle uses the updated count
      next_st.allow = (next_st.credit != '0) && (c < next_st.credit);

      // Register reads, answer one cycle later
      // Unmapped reads return zero
      if (reg_rd) begin
         case (reg_addr)
            EEC_REG_CTRL: begin
               next_st.rdata = {23'h0, st.ack0, st.credit};
            end
            EEC_REG_STAT: begin
               next_st.rdata = {15'h0, st.allow, st.ignored, st.cnt};
            end
            default: begin
               next_st.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         // Only the credit leaves reset nonzero
         st         <= '0;
         st.credit  <= EEC_CREDIT_DEF;
         st.cnt     <= EEC_CNT_RST;
         st.allow   <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Outputs straight from flip-flops
   assign reg_rdata   = st.rdata;
   assign tx_allow    = st.allow;
   assign tx_taken    = st.taken;
   assign credit_cnt  = st.cnt;
   assign seq_done    = st.done;
   assign seq_done_id = st.done_id;
endmodule
`default_nettype wire

// ### eec_pkg.sv
package eec_pkg;
   // ------------------------------------------------------------
   // Sizes and reset values
   // ------------------------------------------------------------
   localparam int          EEC_CNT_W      = 8;       // Counter and credit width
   localparam int          EEC_SEQ_W      = 4;       // Sequence slot index width
   localparam int          EEC_SC_W       = 6;       // SEQ_CNT window width
   localparam logic [7:0]  EEC_CREDIT_DEF = 8'h01;   // Least and default credit
   localparam logic [7:0]  EEC_CNT_RST    = 8'h00;   // Counter after login
   localparam logic [7:0]  EEC_CNT_SOFC1  = 8'h01;   // Counter on connect request
   localparam logic [7:0]  EEC_ONE        = 8'h01;   // Single-frame step

   // ------------------------------------------------------------
   // Register map (word addresses on the plain port)
   // ------------------------------------------------------------
   localparam logic [3:0]  EEC_REG_CTRL   = 4'h0;    // Credit and ACK mode
   localparam logic [3:0]  EEC_REG_STAT   = 4'h1;    // Counter and flags
   localparam logic [3:0]  EEC_REG_RELOG  = 4'h2;    // Write: login done, clears counter

   // CTRL field positions
   localparam int          EEC_CTRL_CR_LSB = 0;      // Credit [7:0]
   localparam int          EEC_CTRL_ACK0   = 8;      // ACK_0 mode

   // Response kinds from the frame receiver
   typedef enum logic [2:0] {
      EEC_RSP_NONE = 3'b000,
      EEC_RSP_ACK0 = 3'b001,
      EEC_RSP_ACK1 = 3'b010,
      EEC_RSP_ACKN = 3'b011,
      EEC_RSP_BSY  = 3'b100,   // F_BSY to data, P_BSY
      EEC_RSP_RJT  = 3'b101    // F_RJT, P_RJT
   } eec_rsp_e;
endpackage

// ### eec_window.sv
`timescale 1ns/1ns
`default_nettype none
// Per-sequence bitmap of unacknowledged SEQ_CNT values
module eec_window
   import eec_pkg::*;
#(
   parameter int SEQS = 16,
   parameter int SCW  = 64
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 srst,
   // Transmit side
   input  wire logic                 tx_mark,
   input  wire logic [EEC_SEQ_W-1:0] tx_seq,
   input  wire logic [EEC_SC_W-1:0]  tx_sc,
   // Reclaim side
   input  wire logic                 rc_do,
   input  wire logic [EEC_SEQ_W-1:0] rc_seq,
   input  wire logic [SCW-1:0]       rc_mask,
   // Current bitmap of rc_seq
   output logic [SCW-1:0]            rc_pend
);
   initial begin
      if (SEQS != (1 << EEC_SEQ_W) || SCW != (1 << EEC_SC_W))
         $error("eec_window size mismatch");
   end

   // Pending bitmaps, one word per sequence slot
   typedef struct packed {
      logic [SEQS-1:0][SCW-1:0] pend;
   } eec_win_s;

   eec_win_s st;
   eec_win_s next_st;

   assign rc_pend = st.pend[rc_seq];

   // Clear reclaimed bits first, then mark the new frame
   always_comb begin
      next_st = st;
      if (rc_do) begin
         next_st.pend[rc_seq] = st.pend[rc_seq] & ~rc_mask;
      end
      if (tx_mark) begin
         next_st.pend[tx_seq][tx_sc] = 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule
`default_nettype wire

// ### eec_top_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Port checks of the credit counter
// ------------------------------------------------------------
module eec_top_checker
   import eec_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 srst,
   // Register port
   input  wire logic [3:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   input  wire logic [31:0]          reg_rdata,
   // Transmit and responses
   input  wire logic                 tx_req,
   input  wire logic                 tx_sofc1,
   input  wire logic                 tx_class1,
   input  wire logic                 tx_allow,
   input  wire logic                 tx_taken,
   input  wire logic                 rsp_valid,
   input  wire eec_rsp_e             rsp_kind,
   input  wire logic [EEC_SEQ_W-1:0] rsp_seq,
   // Status
   input  wire logic [EEC_CNT_W-1:0] credit_cnt,
   input  wire logic                 seq_done,
   input  wire logic [EEC_SEQ_W-1:0] seq_done_id
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // Mode bit shadowed from CTRL writes, since it is not a port
   logic      ack0_mode;
   wire logic relog = reg_wr && (reg_addr == EEC_REG_RELOG);   // Login done
   wire logic acc   = tx_req && tx_allow;                       // Frame accepted
   always_ff @(posedge clk) begin
      if (srst) begin
         ack0_mode <= 1'b0;
      end else if (reg_wr && (reg_addr == EEC_REG_CTRL)) begin
         ack0_mode <= reg_wdata[EEC_CTRL_ACK0];
      end
   end
   chk_taken_cause: assert property (tx_taken |-> $past(acc))
      else $error("frame taken without grant");
   chk_relog_clear: assert property (relog |=> credit_cnt == EEC_CNT_RST)
      else $error("login did not clear count");
   chk_sofc1_load: assert property (acc && tx_sofc1 && tx_class1 && !relog && !ack0_mode
      |=> credit_cnt == EEC_CNT_SOFC1) else $error("connect request not loaded");
   chk_inc_one: assert property (acc && !tx_sofc1 && !rsp_valid && !relog && !ack0_mode
      |=> credit_cnt == $past(credit_cnt) + EEC_ONE) else $error("count not raised");
   chk_ack0_freeze: assert property (ack0_mode && !relog |=> $stable(credit_cnt))
      else $error("count moved in ACK_0 mode");
   chk_idle_hold: assert property (!acc && !rsp_valid && !relog |=> $stable(credit_cnt))
      else $error("count moved without cause");
   chk_no_grow: assert property (rsp_valid && !acc && !relog
      |=> credit_cnt <= $past(credit_cnt)) else $error("response raised count");
   chk_ack0_done: assert property (rsp_valid && rsp_kind == EEC_RSP_ACK0 && !acc && !relog
      |=> seq_done && seq_done_id == $past(rsp_seq) && $stable(credit_cnt))
      else $error("ACK_0 end not flagged");
   chk_stat_read: assert property (reg_rd && reg_addr == EEC_REG_STAT
      |=> reg_rdata[7:0] == $past(credit_cnt)) else $error("status read wrong");
   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
endmodule
bind eec_top eec_top_checker u_chk (.clk(clk), .srst(srst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .tx_req(tx_req), .tx_sofc1(tx_sofc1), .tx_class1(tx_class1), .tx_allow(tx_allow),
   .tx_taken(tx_taken), .rsp_valid(rsp_valid), .rsp_kind(rsp_kind), .rsp_seq(rsp_seq),
   .credit_cnt(credit_cnt), .seq_done(seq_done), .seq_done_id(seq_done_id));
`default_nettype wire

// ### eec_peer.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Remote recipient: launches one response per command
// ------------------------------------------------------------
module eec_peer
   import eec_pkg::*;
#(
   parameter int MAX_N = 7   // Largest N, kept below granted credit
) (
   // Clock, reset and command
   input  wire logic                 clk,
   input  wire logic                 srst,
   input  wire logic                 go,
   input  wire eec_rsp_e             kind,
   input  wire logic [EEC_SEQ_W-1:0] seq,
   input  wire logic [EEC_SC_W-1:0]  sc,
   input  wire logic [EEC_CNT_W-1:0] n,
   input  wire logic                 hist,
   input  wire logic                 term,
   // Response toward the initiator
   output logic                      rsp_valid,
   output eec_rsp_e                  rsp_kind,
   output logic [EEC_SEQ_W-1:0]      rsp_seq,
   output logic [EEC_SC_W-1:0]       rsp_sc,
   output logic [EEC_CNT_W-1:0]      rsp_ackcnt,
   output logic                      rsp_hist,
   output logic                      rsp_term
);
   // One cycle pulse; fields stay so the line never looks released mid-frame
   always_ff @(posedge clk) begin
      rsp_valid  <= go && !srst;
      rsp_kind   <= kind;
      rsp_seq    <= seq;
      rsp_sc     <= sc;
      rsp_ackcnt <= (n > MAX_N) ? EEC_CNT_W'(MAX_N) : n;
      rsp_hist   <= hist;
      rsp_term   <= term;
   end
endmodule
`default_nettype wire

// ### end_to_end_credit_ack_tb.sv
`timescale 1ns/1ns
`default_nettype none
module end_to_end_credit_ack_tb
   import eec_pkg::*;
;
   // ------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------
   logic        clk = 1'b0, srst = 1'b1;
   logic [3:0]  reg_addr = 4'h0, tx_seq = 4'h0, p_seq = 4'h0, seq_done_id;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
   logic        reg_wr = 1'b0, reg_rd = 1'b0, tx_req = 1'b0, tx_sofc1 = 1'b0;
   logic        tx_class1 = 1'b0, tx_allow, tx_taken, seq_done;
   logic [5:0]  tx_sc = 6'h00, p_sc = 6'h00, rsp_sc;
   logic [7:0]  p_n = 8'h00, rsp_ackcnt, credit_cnt;
   logic        p_go = 1'b0, p_h = 1'b0, p_t = 1'b0, rsp_valid, rsp_hist, rsp_term;
   logic [3:0]  rsp_seq;
   eec_rsp_e    p_kind = EEC_RSP_NONE, rsp_kind;
   int          num_errors = 0, n_compared = 0, cyc = 0, i;

   always #50 clk = ~clk;   // 10 MHz

   eec_top #(.SEQS(16)) dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_req(tx_req), .tx_sofc1(tx_sofc1), .tx_class1(tx_class1), .tx_seq(tx_seq),
      .tx_sc(tx_sc), .tx_allow(tx_allow), .tx_taken(tx_taken), .rsp_valid(rsp_valid),
      .rsp_kind(rsp_kind), .rsp_seq(rsp_seq), .rsp_sc(rsp_sc), .rsp_ackcnt(rsp_ackcnt),
      .rsp_hist(rsp_hist), .rsp_term(rsp_term), .credit_cnt(credit_cnt),
      .seq_done(seq_done), .seq_done_id(seq_done_id));
   eec_peer peer (.clk(clk), .srst(srst), .go(p_go), .kind(p_kind), .seq(p_seq),
      .sc(p_sc), .n(p_n), .hist(p_h), .term(p_t), .rsp_valid(rsp_valid),
      .rsp_kind(rsp_kind), .rsp_seq(rsp_seq), .rsp_sc(rsp_sc), .rsp_ackcnt(rsp_ackcnt),
      .rsp_hist(rsp_hist), .rsp_term(rsp_term));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task summarize;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if ((num_errors == 0) && (n_compared > 0)) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         num_errors++;
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      v = reg_rdata;
   endtask
   task cnt(input logic [7:0] e);
      rd(EEC_REG_STAT, d);
      cmp(d[7:0], e);
      cmp(credit_cnt, e);
   endtask
   task snd(input logic [3:0] s, input logic [5:0] c, input logic c1, input logic so);
      @(posedge clk);
      tx_req <= 1'b1;
      tx_seq <= s;
      tx_sc <= c;
      tx_class1 <= c1;
      tx_sofc1 <= so;
      @(posedge clk);
      tx_req <= 1'b0;
   endtask
   // Peer echoes a cycle later; returns after the block has taken it
   task ack(input eec_rsp_e k, input logic [3:0] s, input logic [5:0] c,
            input logic [7:0] n, input logic h, input logic t);
      @(posedge clk);
      p_go <= 1'b1;
      p_kind <= k;
      p_seq <= s;
      p_sc <= c;
      p_n <= n;
      p_h <= h;
      p_t <= t;
      @(posedge clk);
      p_go <= 1'b0;
      @(posedge clk);
   endtask

   // Hang guard: the tests need well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         summarize;
      end
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      rd(EEC_REG_CTRL, d);
      cmp(d[8:0], 9'h001);
      cnt(8'h00);
      rd(4'h3, d);
      cmp(d, 32'h0);
      $display("test reset done");
      snd(4'h0, 6'h00, 1'b0, 1'b0);
      #1 cmp({tx_allow, tx_taken}, 2'b01);
      snd(4'h0, 6'h01, 1'b0, 1'b0);
      cnt(8'h01);
      wr(EEC_REG_CTRL, 32'h0);
      rd(EEC_REG_CTRL, d);
      cmp(d[7:0], 8'h01);
      wr(EEC_REG_RELOG, 32'h0);
      cnt(8'h00);
      $display("test credit done");
      wr(EEC_REG_CTRL, 32'h8);
      for (i = 0; i < 4; i++) snd(4'h1, 6'(i), 1'b0, 1'b0);
      snd(4'h2, 6'h00, 1'b0, 1'b0);
      cnt(8'h05);
      ack(EEC_RSP_ACK1, 4'h1, 6'h01, 8'h01, 1'b1, 1'b0);
      cnt(8'h04);
      ack(EEC_RSP_ACK1, 4'h1, 6'h03, 8'h01, 1'b0, 1'b0);
      cnt(8'h01);
      ack(EEC_RSP_ACK1, 4'h1, 6'h00, 8'h01, 1'b1, 1'b0);
      cnt(8'h01);
      $display("test history done");
      for (i = 1; i < 5; i++) snd(4'h2, 6'(i), 1'b0, 1'b0);
      ack(EEC_RSP_ACKN, 4'h2, 6'h04, 8'h02, 1'b1, 1'b0);
      cnt(8'h03);
      ack(EEC_RSP_BSY, 4'h2, 6'h01, 8'h00, 1'b0, 1'b0);
      cnt(8'h02);
      ack(EEC_RSP_ACK1, 4'h2, 6'h02, 8'h01, 1'b1, 1'b1);
      cnt(8'h00);
      ack(EEC_RSP_RJT, 4'h2, 6'h00, 8'h00, 1'b0, 1'b0);
      cnt(8'h00);
      cmp(d[16:8], 9'h102);
      for (i = 0; i < 4; i++) snd(4'h3, 6'(i), 1'b0, 1'b0);
      ack(EEC_RSP_ACKN, 4'h3, 6'h03, 8'h01, 1'b0, 1'b0);
      cnt(8'h00);
      for (i = 0; i < 4; i++) snd(4'h7, 6'(i), 1'b0, 1'b0);
      ack(EEC_RSP_ACKN, 4'h7, 6'h01, 8'h02, 1'b0, 1'b0);
      cnt(8'h02);
      ack(EEC_RSP_ACK1, 4'h7, 6'h03, 8'h01, 1'b1, 1'b1);
      cnt(8'h00);
      $display("test ack_n done");
      snd(4'h4, 6'h00, 1'b0, 1'b0);
      snd(4'h4, 6'h01, 1'b0, 1'b0);
      snd(4'h5, 6'h00, 1'b1, 1'b1);
      cnt(8'h01);
      ack(EEC_RSP_ACK1, 4'h4, 6'h01, 8'h01, 1'b0, 1'b0);
      cnt(8'h00);
      snd(4'h5, 6'h01, 1'b1, 1'b0);
      cnt(8'h01);
      wr(EEC_REG_RELOG, 32'h0);
      cnt(8'h00);
      $display("test class1 done");
      wr(EEC_REG_CTRL, 32'h108);
      snd(4'h6, 6'h00, 1'b0, 1'b0);
      cnt(8'h00);
      ack(EEC_RSP_ACK0, 4'h6, 6'h00, 8'h00, 1'b0, 1'b1);
      #1 cmp({seq_done, seq_done_id}, 32'h16);
      cnt(8'h00);
      $display("test ack_0 done");
      summarize;
   end
endmodule
`default_nettype wire
